/* src/xmw_defs.vh */
`ifndef XMW_DEFS_VH
`define XMW_DEFS_VH

// register offsets on the plain register port
`define XMW_CTRL_A_OFS 8'h74
`define XMW_CTRL_B_OFS 8'h75

// reset values of both control registers
`define XMW_CTRL_A_RST 8'h00
`define XMW_CTRL_B_RST 8'h00

// control a field positions
`define XMW_A_ENABLE_BIT 7
`define XMW_A_LIMIT_MSB 6
`define XMW_A_LIMIT_LSB 4
`define XMW_A_UPPER_MSB 3
`define XMW_A_UPPER_LSB 2
`define XMW_A_LOWER_MSB 1
`define XMW_A_LOWER_LSB 0

// control b field positions
`define XMW_B_KEEPER_BIT 7
`define XMW_B_MASK_MSB 2
`define XMW_B_MASK_LSB 0

// external address space and sector geometry
`define XMW_EXT_BASE 16'h2200
`define XMW_EXT_TOP 16'hFFFF
`define XMW_SECT_SHIFT 13

// wait-select encodings
`define XMW_WAIT_NONE 2'h0
`define XMW_WAIT_ONE 2'h1
`define XMW_WAIT_TWO 2'h2
`define XMW_WAIT_TWO_GAP 2'h3

// high address mask code that frees the whole high port
`define XMW_MASK_ALL_FREE 3'h7

`endif

/* src/xmw_sector_decode.v */
`timescale 1ns/1ps
`include "xmw_defs.vh"

// picks the sector of an access and turns its wait-select code into counts
module xmw_sector_decode (
    input wire [15:0] addr,
    input wire [2:0] sector_limit_sel,
    input wire [1:0] upper_wait_sel,
    input wire [1:0] lower_wait_sel,
    output reg in_lower,
    output reg [1:0] wait_cycles,
    output reg idle_gap
);
    reg [15:0] boundary;
    reg [1:0] code;

    // sector limit and wait-state decode
    always @* begin
        boundary = {sector_limit_sel, 13'h0000};
        // codes 000 and 001 leave one sector, the upper one
        if (sector_limit_sel[2:1] == 2'h0) begin // RQ2 RQ3
            in_lower = 1'b0;
        end else begin
            in_lower = (addr < boundary); // RQ4 RQ16
        end
        code = in_lower ? lower_wait_sel : upper_wait_sel; // RQ5 RQ6 RQ7
        case (code)
            `XMW_WAIT_NONE: begin
                wait_cycles = 2'h0; // RQ8
                idle_gap = 1'b0;
            end
            `XMW_WAIT_ONE: begin
                wait_cycles = 2'h1; // RQ8
                idle_gap = 1'b0;
            end
            `XMW_WAIT_TWO: begin
                wait_cycles = 2'h2; // RQ8
                idle_gap = 1'b0;
            end
            default: begin
                wait_cycles = 2'h2; // RQ9
                idle_gap = 1'b1; // RQ9
            end
        endcase
    end
endmodule

/* src/xmw_ext_mem_cfg.v */
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`include "xmw_defs.vh"

// Summary of operation
// (RQ1) enable bit hands pins to the interface
// (RQ2) limit zero means one single sector
// (RQ3) code 00x: upper sector 0x2200 to 0xFFFF
// (RQ4) codes 010-111 move upper start by 0x2000
// (RQ5) single sector uses upper wait select
// (RQ6) upper sector waits from bits 3:2
// (RQ7) lower sector waits from bits 1:0
// (RQ8) codes 00/01/10 add 0/1/2 strobe waits
// (RQ9) code 11: two waits plus idle cycle
// (RQ10) keeper bit holds address/data lines when released
// (RQ11) keeper works even with interface disabled
// (RQ12) control b bits 6:3 read zero
// (RQ13) mask zero drives all eight high pins
// (RQ14) each mask step up to 6 frees one more top pin; code 7 frees all
// (RQ15) software may reach all 64KB via mask
// (RQ16) sector compare picks each access's waits
module xmw_ext_mem_cfg #(
    parameter ADDR_W = 8
) (
    input wire clk,
    input wire resetn,
    // register port
    input wire [ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output wire [7:0] reg_rdata,
    // access requests from the core
    input wire acc_req,
    input wire acc_we,
    input wire [15:0] acc_addr,
    input wire [7:0] acc_wdata,
    output wire acc_ready,
    output wire acc_done,
    output wire [7:0] acc_rdata,
    // multiplexed address/data pins
    input wire [7:0] muxed_addr_data_in,
    output wire [7:0] muxed_addr_data_out,
    output wire muxed_addr_data_oe,
    output wire [7:0] keeper_value,
    output wire keeper_active,
    // high address pins and port release
    output wire [7:0] high_addr_lines,
    output wire [7:0] high_addr_owned,
    // strobes, active low except the latch strobe; pin override and sector flag are active high
    output wire addr_latch,
    output wire wr_strobe_n,
    output wire rd_strobe_n,
    output wire pin_override,
    output wire lower_sector_access
);
    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_STROBE = 3'h2;
    localparam ST_HOLD = 3'h3;
    localparam ST_GAP = 3'h4;
    localparam ST_SAMPLE = 3'h5;

    reg [7:0] ctrl_a_ff;
    reg [7:0] nxt_ctrl_a;
    reg [7:0] ctrl_b_ff;
    reg [7:0] nxt_ctrl_b;
    reg [7:0] rdata_ff;
    reg [7:0] nxt_rdata;
    reg [2:0] state_ff;
    reg [2:0] nxt_state;
    reg [1:0] wait_cnt_ff;
    reg [1:0] nxt_wait_cnt;
    reg gap_ff;
    reg nxt_gap;
    reg short_ff;
    reg nxt_short;
    reg we_ff;
    reg nxt_we;
    reg lower_ff;
    reg nxt_lower;
    reg [15:0] addr_ff;
    reg [15:0] nxt_addr;
    reg [7:0] wdata_ff;
    reg [7:0] nxt_wdata;
    reg [7:0] acc_rdata_ff;
    reg [7:0] nxt_acc_rdata;
    reg done_ff;
    reg nxt_done;
    reg [7:0] ad_out_ff;
    reg [7:0] nxt_ad_out;
    reg ad_oe_ff;
    reg nxt_ad_oe;
    reg ale_ff;
    reg nxt_ale;
    reg wr_n_ff;
    reg nxt_wr_n;
    reg rd_n_ff;
    reg nxt_rd_n;
    reg [7:0] keep_ff;
    reg [7:0] nxt_keep;
    reg [7:0] ad_sync1_ff;
    reg [7:0] ad_sync2_ff;

    wire if_enable;
    wire [2:0] limit_sel;
    wire [2:0] mask_sel;
    wire keeper_en;
    wire dec_lower;
    wire [1:0] dec_wait;
    wire dec_gap;

    // mask of the high address pins a mask code leaves with the interface
    function [7:0] high_pin_mask;
        input [2:0] code;
        begin
            if (code == `XMW_MASK_ALL_FREE) begin
                high_pin_mask = 8'h00; // RQ14
            end else begin
                high_pin_mask = 8'hFF >> code; // RQ13 RQ14
            end
        end
    endfunction

    // decodes a register address, used for both reads and writes
    function is_reg;
        input [ADDR_W-1:0] a;
        input [7:0] ofs;
        begin
            is_reg = (a == ofs[ADDR_W-1:0]);
        end
    endfunction

    assign if_enable = ctrl_a_ff[`XMW_A_ENABLE_BIT];
    assign limit_sel = ctrl_a_ff[`XMW_A_LIMIT_MSB:`XMW_A_LIMIT_LSB];
    assign mask_sel = ctrl_b_ff[`XMW_B_MASK_MSB:`XMW_B_MASK_LSB];
    assign keeper_en = ctrl_b_ff[`XMW_B_KEEPER_BIT];

    // sector and wait decode for the address offered on the request port
    xmw_sector_decode u_decode (
        .addr(acc_addr),
        .sector_limit_sel(limit_sel),
        .upper_wait_sel(ctrl_a_ff[`XMW_A_UPPER_MSB:`XMW_A_UPPER_LSB]),
        .lower_wait_sel(ctrl_a_ff[`XMW_A_LOWER_MSB:`XMW_A_LOWER_LSB]),
        .in_lower(dec_lower),
        .wait_cycles(dec_wait),
        .idle_gap(dec_gap)
    );

    // register writes; reserved bits of control b are never stored
    always @* begin
        nxt_ctrl_a = ctrl_a_ff;
        nxt_ctrl_b = ctrl_b_ff;
        if (reg_wr && is_reg(reg_addr, `XMW_CTRL_A_OFS)) begin
            nxt_ctrl_a = reg_wdata;
        end
        if (reg_wr && is_reg(reg_addr, `XMW_CTRL_B_OFS)) begin
            nxt_ctrl_b = reg_wdata & 8'h87; // RQ12
        end
    end

    // read data stand in the cycle after the strobe only; unmapped reads zero
    always @* begin
        nxt_rdata = 8'h00;
        if (reg_rd && is_reg(reg_addr, `XMW_CTRL_A_OFS)) begin
            nxt_rdata = ctrl_a_ff;
        end else if (reg_rd && is_reg(reg_addr, `XMW_CTRL_B_OFS)) begin
            nxt_rdata = {ctrl_b_ff[7], 4'h0, ctrl_b_ff[2:0]}; // RQ12
        end
    end

    // access sequencer: address phase, stretched strobe, hold, optional gap
    always @* begin
        nxt_state = state_ff;
        nxt_wait_cnt = wait_cnt_ff;
        nxt_gap = gap_ff;
        nxt_short = short_ff;
        nxt_we = we_ff;
        nxt_lower = lower_ff;
        nxt_addr = addr_ff;
        nxt_wdata = wdata_ff;
        nxt_acc_rdata = acc_rdata_ff;
        nxt_done = 1'b0;
        nxt_ad_out = ad_out_ff;
        nxt_ad_oe = ad_oe_ff;
        nxt_ale = 1'b0;
        nxt_wr_n = 1'b1;
        nxt_rd_n = 1'b1;
        case (state_ff)
            ST_IDLE: begin
                nxt_ad_oe = 1'b0;
                if (acc_req && if_enable) begin
                    // sector and waits are frozen here for the whole access
                    nxt_state = ST_ADDR;
                    nxt_we = acc_we;
                    nxt_addr = acc_addr;
                    nxt_wdata = acc_wdata;
                    nxt_lower = dec_lower; // RQ16
                    nxt_wait_cnt = dec_wait; // RQ8
                    nxt_gap = dec_gap; // RQ9
                    nxt_short = (dec_wait == 2'h0) && !acc_we;
                    nxt_ale = 1'b1;
                    nxt_ad_out = acc_addr[7:0];
                    nxt_ad_oe = 1'b1;
                end
            end
            ST_ADDR: begin
                nxt_state = ST_STROBE;
                nxt_wr_n = ~we_ff;
                nxt_rd_n = we_ff;
                nxt_ad_out = we_ff ? wdata_ff : ad_out_ff;
                nxt_ad_oe = we_ff; // reads release the lines to the memory
            end
            ST_STROBE: begin
                if (wait_cnt_ff != 2'h0) begin
                    // each remaining wait keeps the strobe low one more cycle
                    nxt_wait_cnt = wait_cnt_ff - 2'h1; // RQ8
                    nxt_wr_n = ~we_ff;
                    nxt_rd_n = we_ff;
                end else begin
                    nxt_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                nxt_ad_oe = 1'b0;
                if (short_ff) begin
                    // a one-cycle read strobe has not yet left the synchroniser
                    nxt_state = ST_SAMPLE;
                end else begin
                    // with waits, stage two already holds a strobe-phase sample
                    if (!we_ff) begin
                        nxt_acc_rdata = ad_sync2_ff;
                    end
                    nxt_done = 1'b1;
                    nxt_state = gap_ff ? ST_GAP : ST_IDLE; // RQ9
                end
            end
            ST_SAMPLE: begin
                // zero-wait reads pay one cycle here; the strobe width is unchanged
                nxt_acc_rdata = ad_sync2_ff;
                nxt_done = 1'b1;
                nxt_state = ST_IDLE;
            end
            ST_GAP: begin
                // one dead cycle before a new address goes out
                nxt_state = ST_IDLE; // RQ9
            end
            default: begin
                nxt_state = ST_IDLE;
                nxt_ad_oe = 1'b0;
            end
        endcase
    end

    // keeper remembers the last value driven onto the muxed lines
    always @* begin
        nxt_keep = keep_ff;
        if (ad_oe_ff) begin
            nxt_keep = ad_out_ff; // RQ10
        end
    end

    // control registers
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_a_ff <= `XMW_CTRL_A_RST;
            ctrl_b_ff <= `XMW_CTRL_B_RST;
            rdata_ff <= 8'h00;
        end else begin
            ctrl_a_ff <= nxt_ctrl_a;
            ctrl_b_ff <= nxt_ctrl_b;
            rdata_ff <= nxt_rdata;
        end
    end

    // sequencer and pin registers
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= ST_IDLE;
            wait_cnt_ff <= 2'h0;
            gap_ff <= 1'b0;
            short_ff <= 1'b0;
            we_ff <= 1'b0;
            lower_ff <= 1'b0;
            addr_ff <= 16'h0000;
            wdata_ff <= 8'h00;
            acc_rdata_ff <= 8'h00;
            done_ff <= 1'b0;
            ad_out_ff <= 8'h00;
            ad_oe_ff <= 1'b0;
            ale_ff <= 1'b0;
            wr_n_ff <= 1'b1;
            rd_n_ff <= 1'b1;
            keep_ff <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            wait_cnt_ff <= nxt_wait_cnt;
            gap_ff <= nxt_gap;
            short_ff <= nxt_short;
            we_ff <= nxt_we;
            lower_ff <= nxt_lower;
            addr_ff <= nxt_addr;
            wdata_ff <= nxt_wdata;
            acc_rdata_ff <= nxt_acc_rdata;
            done_ff <= nxt_done;
            ad_out_ff <= nxt_ad_out;
            ad_oe_ff <= nxt_ad_oe;
            ale_ff <= nxt_ale;
            wr_n_ff <= nxt_wr_n;
            rd_n_ff <= nxt_rd_n;
            keep_ff <= nxt_keep;
        end
    end

    // two-stage synchroniser on the pad inputs; only stage two is read
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ad_sync1_ff <= 8'h00;
            ad_sync2_ff <= 8'h00;
        end else begin
            ad_sync1_ff <= muxed_addr_data_in;
            ad_sync2_ff <= ad_sync1_ff;
        end
    end

    assign reg_rdata = rdata_ff;
    // new requests wait while an access or its gap is running
    assign acc_ready = (state_ff == ST_IDLE) && if_enable;
    assign acc_done = done_ff;
    assign acc_rdata = acc_rdata_ff;
    assign muxed_addr_data_out = ad_out_ff;
    assign muxed_addr_data_oe = ad_oe_ff && if_enable; // RQ1
    // keeper is deliberately not gated by the interface enable
    assign keeper_active = keeper_en && !muxed_addr_data_oe; // RQ10 RQ11
    assign keeper_value = keep_ff; // RQ10
    // full address byte kept; the mask only decides which pins carry it
    assign high_addr_lines = addr_ff[15:8]; // RQ15
    assign high_addr_owned = if_enable ? high_pin_mask(mask_sel) : 8'h00; // RQ1 RQ13 RQ14
    assign addr_latch = ale_ff;
    assign wr_strobe_n = wr_n_ff;
    assign rd_strobe_n = rd_n_ff;
    assign pin_override = if_enable; // RQ1
    assign lower_sector_access = lower_ff;
endmodule

/* verification/xmw_cfg_properties.sv */
`timescale 1ns/1ps
`include "xmw_defs.vh"
module xmw_cfg_props #(
    parameter ADDR_W = 8
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic acc_req,
    input wire logic acc_we,
    input wire logic acc_ready,
    input wire logic acc_done,
    input wire logic [15:0] acc_addr,
    input wire logic muxed_addr_data_oe,
    input wire logic keeper_active,
    input wire logic [7:0] high_addr_lines,
    input wire logic [7:0] high_addr_owned,
    input wire logic addr_latch,
    input wire logic wr_strobe_n,
    input wire logic rd_strobe_n,
    input wire logic pin_override,
    input wire logic lower_sector_access
);
    logic [7:0] a_ff;
    logic [7:0] b_ff;
    logic lower;
    logic [1:0] code;
    logic stb;
    logic take;
    // shadow copies of both control registers, so outputs are tied to bus writes
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            a_ff <= 8'h00;
            b_ff <= 8'h00;
        end else if (reg_wr && reg_addr == `XMW_CTRL_A_OFS) begin
            a_ff <= reg_wdata;
        end else if (reg_wr && reg_addr == `XMW_CTRL_B_OFS) begin
            b_ff <= reg_wdata;
        end
    end
    // expected sector and wait code for the address on offer
    assign lower = a_ff[6:5] != 2'b00 && acc_addr < {a_ff[6:4], 13'h0000};
    assign code = lower ? a_ff[1:0] : a_ff[3:2];
    assign stb = !rd_strobe_n || !wr_strobe_n;
    assign take = acc_req && acc_ready;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // access phases: latch cycle, strobe of 1+W cycles, release, done
    sequence s_w0;
        addr_latch ##1 stb ##1 !stb ##1 acc_done;
    endsequence
    // zero-wait reads spend one extra cycle before done for the synchroniser
    sequence s_r0;
        addr_latch ##1 stb ##1 !stb ##1 !acc_done ##1 acc_done;
    endsequence
    sequence s_w1;
        addr_latch ##1 stb [*2] ##1 !stb ##1 acc_done;
    endsequence
    sequence s_w2;
        addr_latch ##1 stb [*3] ##1 !stb ##1 acc_done;
    endsequence
    a_enable_pins: assert property (pin_override == a_ff[7] && (acc_ready -> a_ff[7]))
        else $error("pin override does not follow enable");
    a_mask_release: assert property (high_addr_owned == (!a_ff[7] ? 8'h00 :
        (b_ff[2:0] == 3'h7 ? 8'h00 : 8'hff >> b_ff[2:0]))) else $error("high pin mask wrong");
    a_keeper_state: assert property (keeper_active == (b_ff[7] && !muxed_addr_data_oe))
        else $error("keeper state wrong");
    a_ctrl_b_read: assert property (reg_rd && reg_addr == `XMW_CTRL_B_OFS |=>
        reg_rdata == {b_ff[7], 4'h0, b_ff[2:0]}) else $error("control b read wrong");
    a_wait_none: assert property (take && acc_we && code == 2'h0 |=> s_w0)
        else $error("zero wait access timing wrong");
    a_read_settle: assert property (take && !acc_we && code == 2'h0 |=> s_r0)
        else $error("zero wait read timing wrong");
    a_wait_one: assert property (take && code == 2'h1 |=> s_w1)
        else $error("one wait access timing wrong");
    a_wait_two: assert property (take && code == 2'h2 |=> s_w2 ##0 acc_ready)
        else $error("two wait access timing wrong");
    a_wait_gap: assert property (take && code == 2'h3 |=> s_w2 ##0 !acc_ready)
        else $error("idle gap missing");
    a_high_byte: assert property (take |=> high_addr_lines == $past(acc_addr[15:8]))
        else $error("high address byte wrong");
    a_sector_flag: assert property (take |=> lower_sector_access == $past(lower))
        else $error("sector flag wrong");
endmodule
bind xmw_ext_mem_cfg xmw_cfg_props #(.ADDR_W(ADDR_W)) u_props (.clk(clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .acc_req(acc_req), .acc_we(acc_we), .acc_ready(acc_ready),
    .acc_done(acc_done),
    .acc_addr(acc_addr), .muxed_addr_data_oe(muxed_addr_data_oe),
    .keeper_active(keeper_active), .high_addr_lines(high_addr_lines),
    .high_addr_owned(high_addr_owned), .addr_latch(addr_latch), .wr_strobe_n(wr_strobe_n),
    .rd_strobe_n(rd_strobe_n), .pin_override(pin_override),
    .lower_sector_access(lower_sector_access));

/* verification/xmw_sram_model.sv */
`timescale 1ns/1ps
module xmw_sram_model (
    input wire logic clk,
    input wire logic addr_latch,
    input wire logic wr_strobe_n,
    input wire logic rd_strobe_n,
    input wire logic [7:0] ad_out,
    input wire logic ad_oe,
    input wire logic [7:0] hi,
    input wire logic keep_on,
    input wire logic [7:0] keep_val,
    output wire logic [7:0] ad_in
);
    logic [7:0] mem [0:65535];
    logic [7:0] lo_ff;
    logic [7:0] last_ff = 8'h00;
    // low address byte is caught while the latch strobe is high
    always @(posedge clk) begin
        if (addr_latch) begin
            lo_ff <= ad_out;
        end
        last_ff <= ad_in;
    end
    // data is taken on the trailing edge of the write strobe
    always @(posedge wr_strobe_n) begin
        mem[{hi, lo_ff}] <= ad_out;
    end
    // undriven lines float, so show a moving pattern rather than a stale byte
    assign ad_in = ad_oe ? ad_out : !rd_strobe_n ? mem[{hi, lo_ff}] :
        keep_on ? keep_val : ~last_ff;
endmodule

/* verification/testbench.sv */
`timescale 1ns/1ps
`include "xmw_defs.vh"
module testbench;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic acc_req = 1'b0;
    logic acc_we = 1'b0;
    logic [15:0] acc_addr = 16'h0000;
    logic [7:0] acc_wdata = 8'h00;
    logic [7:0] reg_rdata, acc_rdata, ad_in, ad_out, kv, hi, own;
    logic acc_ready, acc_done, oe, keep_on, ale, wr_n, rd_n, pin_override, low;
    logic [15:0] lat;
    logic [15:0] w;
    int n_mismatch = 0;
    int checks_done = 0;
    xmw_ext_mem_cfg #(.ADDR_W(8)) dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .acc_req(acc_req), .acc_we(acc_we), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
        .acc_ready(acc_ready), .acc_done(acc_done), .acc_rdata(acc_rdata),
        .muxed_addr_data_in(ad_in), .muxed_addr_data_out(ad_out), .muxed_addr_data_oe(oe),
        .keeper_value(kv), .keeper_active(keep_on), .high_addr_lines(hi),
        .high_addr_owned(own), .addr_latch(ale), .wr_strobe_n(wr_n), .rd_strobe_n(rd_n),
        .pin_override(pin_override), .lower_sector_access(low));
    xmw_sram_model mem (.clk(clk), .addr_latch(ale), .wr_strobe_n(wr_n), .rd_strobe_n(rd_n),
        .ad_out(ad_out), .ad_oe(oe), .hi(hi), .keep_on(keep_on), .keep_val(kv), .ad_in(ad_in));
    // 250 MHz clock
    always #2 clk = ~clk;
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(negedge clk);
    endtask
    task rdchk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk(reg_rdata, e);
    endtask
    // hold the request until the edge that takes it, then count to done
    task acc(input logic we, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        acc_req <= 1'b1;
        acc_we <= we;
        acc_addr <= a;
        acc_wdata <= d;
        lat = 0;
        do begin @(negedge clk); lat++; end while (acc_ready !== 1'b1 && lat < 50);
        @(posedge clk);
        acc_req <= 1'b0;
        lat = 0;
        do begin @(negedge clk); lat++; end while (acc_done !== 1'b1 && lat < 50);
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // the whole run is a few hundred cycles, so this only fires on a hang
    initial begin
        #200000;
        n_mismatch++;
        test_done();
    end
    initial begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        rdchk(`XMW_CTRL_A_OFS, 8'h00);
        rdchk(`XMW_CTRL_B_OFS, 8'h00);
        wr(8'h76, 8'hff);
        rdchk(8'h76, 8'h00);
        chk(acc_ready, 1'b0);
        wr(`XMW_CTRL_B_OFS, 8'hff);
        rdchk(`XMW_CTRL_B_OFS, 8'h87);
        chk(keep_on, 1'b1);
        chk(own, 8'h00);
        $display("test registers done");
        wr(`XMW_CTRL_A_OFS, 8'h80);
        for (int m = 0; m < 8; m++) begin
            wr(`XMW_CTRL_B_OFS, 8'(m));
            chk(own, m == 7 ? 8'h00 : 8'hff >> m);
            chk(pin_override, 1'b1);
        end
        $display("test high mask done");
        wr(`XMW_CTRL_B_OFS, 8'h80);
        // single sector: every wait code, write then read back
        for (int c = 0; c < 4; c++) begin
            w = (c > 1) ? 2 : c;
            wr(`XMW_CTRL_A_OFS, 8'h80 | 8'(c << 2));
            acc(1'b1, 16'h3000 + 16'(c), 8'h5a ^ 8'(c));
            chk(lat, 16'h0004 + w);
            chk(kv, 8'h5a ^ 8'(c));
            chk(hi, 8'h30);
            acc(1'b0, 16'h3000 + 16'(c), 8'h00);
            // a zero-wait read needs one more cycle to pass the pad synchroniser
            chk(lat, (c == 0) ? 16'h0005 : 16'h0004 + w);
            chk(acc_rdata, 8'h5a ^ 8'(c));
            chk(acc_ready, c != 3);
        end
        $display("test wait codes done");
        // upper waits two, lower waits one; probe each side of the limit
        for (int l = 0; l < 8; l++) begin
            wr(`XMW_CTRL_A_OFS, 8'h89 | 8'(l << 4));
            if (l > 1) begin
                acc(1'b0, 16'(l << 13) - 16'h0001, 8'h00);
                chk(lat, 16'h0005);
                chk(low, 1'b1);
                acc(1'b0, 16'(l << 13), 8'h00);
            end else begin
                acc(1'b0, 16'h2200, 8'h00);
            end
            chk(lat, 16'h0006);
            chk(low, 1'b0);
        end
        $display("test sectors done");
        wr(`XMW_CTRL_A_OFS, 8'h00);
        chk(keep_on, 1'b1);
        chk(own, 8'h00);
        $display("test disable done");
        test_done();
    end
endmodule
